// ---- hdl/flash_cmd_pkg.sv ----
// constants, types and helpers shared by the flash instruction logic
package flash_cmd_pkg;

   // ==========================================================
   // instruction codes
   localparam logic [7:0] OP_ENTER_4B     = 8'hb7;
   localparam logic [7:0] OP_EXIT_4B      = 8'he9;
   localparam logic [7:0] OP_ENTER_QUAD   = 8'h38;
   localparam logic [7:0] OP_EXIT_QUAD    = 8'hff;
   localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
   localparam logic [7:0] OP_RESET        = 8'h99;
   localparam logic [7:0] OP_READ         = 8'h03;
   localparam logic [7:0] OP_READ_4B      = 8'h13;
   localparam logic [7:0] OP_FAST_READ    = 8'h0b;
   localparam logic [7:0] OP_DTR_READ     = 8'h0d;
   localparam logic [7:0] OP_FAST_READ_4B = 8'h0c;
   localparam logic [7:0] OP_SET_PARAM    = 8'hc0;
   localparam logic [7:0] OP_WRITE_EXT    = 8'hc5;

   // ==========================================================
   // address and dummy figures
   localparam logic [5:0] ADDR3_BITS      = 6'd24;
   localparam logic [5:0] ADDR4_BITS      = 6'd32;
   localparam logic [3:0] SPI_FAST_DUMMY  = 4'd8;
   localparam logic [3:0] DTR_DUMMY       = 4'd6;
   localparam logic [3:0] SPI_CMD_EDGES   = 4'd8;
   localparam logic [3:0] QUAD_CMD_EDGES  = 4'd2;
   localparam logic [3:0] SPI_GROUPS      = 4'd8;
   localparam logic [3:0] QUAD_GROUPS     = 4'd2;
   localparam logic [3:0] SPI_OUT_OE      = 4'h2;
   localparam logic [3:0] QUAD_OUT_OE     = 4'hf;

   // ==========================================================
   // reset values and position of the dummy field in the parameter
   localparam logic [7:0] EXT_ADDR_RESET  = 8'h00;
   localparam logic [7:0] READ_PARAM_RESET = 8'h00;
   localparam int         PARAM_DUMMY_LSB = 4;

   // ==========================================================
   // timing: recovery after reset, figures in ns
   localparam int RECOVERY_NS     = 300000;
   localparam int CLK_PERIOD_NS   = 5;
   localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // link phases
   typedef enum logic [2:0] {
      ST_CMD,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_BYTE,
      ST_IGNORE
   } link_state_t;

   // quad-mode fast read dummy clocks from the two parameter bits
   function automatic logic [3:0] param_dummy(input logic [1:0] p);
      unique case (p)
         2'd0, 2'd1: param_dummy = 4'd4;
         2'd2:       param_dummy = 4'd6;
         2'd3:       param_dummy = 4'd8;
      endcase
   endfunction

endpackage

// ---- hdl/sync_bit.sv ----
// two-flop synchroniser for one level
`timescale 1ns/1ps
module sync_bit (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_reg <= 1'b0;
         q_o      <= 1'b0;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule

// ---- hdl/recovery_timer.sv ----
// reset recovery timer and software reset pulse on the reference clock
`timescale 1ns/1ps
module recovery_timer #(
   parameter int CYCLES = flash_cmd_pkg::RECOVERY_CYCLES
) (
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   input  wire logic req_tog_i,
   output logic      busy_o,
   output logic      pulse_o
);
   import flash_cmd_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);

   logic          tog_reg;
   logic [CW-1:0] count_reg;
   wire           req_evt = req_tog_i ^ tog_reg;

   // busy from power reset or each accepted software reset
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         tog_reg   <= 1'b0;
         busy_o    <= 1'b1;
         pulse_o   <= 1'b0;
         count_reg <= CW'(CYCLES - 1);
      end else begin
         tog_reg <= req_tog_i;
         pulse_o <= req_evt;
         if (req_evt) begin
            busy_o    <= 1'b1;
            count_reg <= CW'(CYCLES - 1);
         end else if (busy_o) begin
            if (count_reg == '0) begin
               busy_o <= 1'b0;
            end else begin
               count_reg <= count_reg - CW'(1);
            end
         end
      end
   end
endmodule

// ---- hdl/flash_cmd_core.sv ----
// serial flash instruction interpreter: modes, software reset and reads
`timescale 1ns/1ps

// Function
// - B7h switches to 32-bit addressing
// - E9h returns to 24-bit addressing
// - SPI or quad mode, 38h enters quad
// - power-up starts in SPI mode
// - 38h ignored while quad enable clear
// - entering quad keeps latch, suspend, wrap
// - FFh leaves quad, keeps latch, suspend, wrap
// - 66h then 99h; anything else disarms
// - accepted reset restores power-on defaults
// - all instructions refused during reset recovery
// - 03h: address in, data out falling
// - address increments per byte until deselect
// - read rejected while write in progress
// - 13h always 32-bit, SPI only
// - 13h ignored while write in progress
// - 0Bh: address, dummy, then data
// - quad fast read dummy from parameter
// - parameter dummy defaults to four clocks
// - 0Dh: both edges, six dummy clocks
// - 0Dh also valid in quad mode
// - 0Ch 32-bit in SPI, wrap in quad
// - 3-byte mode takes top byte from register
// - extended address cleared on any reset
// - address size bit shows 4-byte mode
module flash_cmd_core #(
   parameter int RECOVERY_CYCLES = flash_cmd_pkg::RECOVERY_CYCLES
) (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  io_i,
   output logic      [3:0]  io_o,
   output logic      [3:0]  io_oe_o,
   input  wire logic        quad_enable_bit_i,
   input  wire logic        write_in_progress_flag_i,
   input  wire logic        write_enable_latch_i,
   output logic             address_size_bit_o,
   output logic             quad_command_mode_o,
   output logic             soft_reset_o,
   output logic             reset_busy_o,
   output logic      [31:0] mem_addr_o,
   output logic             mem_rd_o,
   input  wire logic [7:0]  mem_data_i
);
   import flash_cmd_pkg::*;

   // ==========================================================
   // helpers

   // shift one bit or one nibble into the receive register
   function automatic logic [35:0] shift_in(input logic [35:0] r, input logic [3:0] d, input logic q);
      shift_in = q ? {r[31:0], d} : {r[34:0], d[0]};
   endfunction

   // output group of a byte, msb first, mapped onto the data lines
   function automatic logic [3:0] group_sel(input logic [7:0] b, input logic [3:0] idx, input logic q);
      if (q) begin
         group_sel = idx[0] ? b[3:0] : b[7:4];
      end else begin
         group_sel = {2'b00, b[3'd7 - idx[2:0]], 1'b0};
      end
   endfunction

   // next read address, optionally wrapping inside an aligned burst
   function automatic logic [31:0] next_addr(input logic [31:0] a, input logic w, input logic [1:0] len);
      logic [31:0] mask;
      mask = (32'h8 << len) - 32'h1;
      next_addr = w ? ((a & ~mask) | ((a + 32'h1) & mask)) : a + 32'h1;
   endfunction

   // ==========================================================
   // clock crossings
   logic qe_s, wip_s, wel_s, busy_s;
   logic four_byte_reg, qpi_reg, armed_reg, rst_tog_reg, tog_s;
   logic [7:0] ext_addr_reg, param_reg;

   // reference-domain levels into the link domain
   sync_bit u_qe   (.clk_i(sclk_i), .reset_i(1'b0), .d_i(quad_enable_bit_i), .q_o(qe_s));
   sync_bit u_wip  (.clk_i(sclk_i), .reset_i(1'b0), .d_i(write_in_progress_flag_i), .q_o(wip_s));
   sync_bit u_wel  (.clk_i(sclk_i), .reset_i(1'b0), .d_i(write_enable_latch_i), .q_o(wel_s));
   sync_bit u_busy (.clk_i(sclk_i), .reset_i(1'b0), .d_i(reset_busy_o), .q_o(busy_s));

   // link-domain state back to the reference clock
   sync_bit u_ads  (.clk_i(ref_clk_i), .reset_i(reset_i), .d_i(four_byte_reg), .q_o(address_size_bit_o));
   sync_bit u_qpi  (.clk_i(ref_clk_i), .reset_i(reset_i), .d_i(qpi_reg), .q_o(quad_command_mode_o));
   sync_bit u_tog  (.clk_i(ref_clk_i), .reset_i(reset_i), .d_i(rst_tog_reg), .q_o(tog_s));

   // recovery window after power reset or software reset
   recovery_timer #(
      .CYCLES (RECOVERY_CYCLES)
   ) u_recovery (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .req_tog_i (tog_s),
      .busy_o    (reset_busy_o),
      .pulse_o   (soft_reset_o)
   );

   // ==========================================================
   // frame registers
   link_state_t state_reg;
   logic [5:0]  cnt_reg;
   logic [35:0] rx_reg;
   logic [5:0]  len_reg;
   logic [3:0]  dummy_reg;
   logic        dtr_reg;
   logic        wrap_reg;
   logic        ext_sel_reg;
   logic [31:0] addr_reg;
   logic [3:0]  fall_in_reg;
   logic [3:0]  fall_q_reg;
   logic [3:0]  rise_q_reg;
   logic [7:0]  tx_reg;
   logic [3:0]  pos_reg;
   logic        loaded_reg;
   logic [31:0] rd_addr_reg;

   // ==========================================================
   // instruction decode
   wire [3:0]  cmd_edges = qpi_reg ? QUAD_CMD_EDGES : SPI_CMD_EDGES;
   wire [35:0] rx_next   = shift_in(rx_reg, io_i, qpi_reg);
   wire [35:0] rx_dtr    = shift_in(shift_in(rx_reg, fall_in_reg, qpi_reg), io_i, qpi_reg);
   wire [7:0]  opcode    = rx_next[7:0];
   wire        cmd_done  = (state_reg == ST_CMD) && (cnt_reg == {2'b00, cmd_edges} - 6'd1);
   wire        byte_done = (state_reg == ST_BYTE) && (cnt_reg == {2'b00, cmd_edges} - 6'd1);

   // read families, each gated by the mode it is valid in
   wire op_spi_only = (opcode == OP_READ_4B) || (opcode == OP_FAST_READ_4B);
   wire op_read     = (opcode == OP_READ) || (opcode == OP_FAST_READ)
                   || (opcode == OP_DTR_READ)
                   || (op_spi_only && !qpi_reg)
                   || ((opcode == OP_FAST_READ_4B) && qpi_reg);
   wire op_wide     = op_spi_only && !qpi_reg;
   wire op_wrap     = (opcode == OP_FAST_READ_4B) && qpi_reg;
   wire op_dtr      = (opcode == OP_DTR_READ);
   wire op_param    = (opcode == OP_SET_PARAM) && qpi_reg;
   wire op_ext      = (opcode == OP_WRITE_EXT) && wel_s;
   wire op_fast     = (opcode == OP_FAST_READ) || (opcode == OP_FAST_READ_4B);

   // address length and dummy clocks of the decoded read
   wire [5:0] op_len   = (op_wide || four_byte_reg) ? ADDR4_BITS : ADDR3_BITS;
   wire [3:0] op_dummy = op_dtr ? DTR_DUMMY
                       : !op_fast ? 4'd0
                       : qpi_reg ? param_dummy(param_reg[PARAM_DUMMY_LSB +: 2])
                       : SPI_FAST_DUMMY;

   // rising edges spent on the address; double rate also eats the first dummy
   wire [5:0] addr_sdr   = qpi_reg ? (len_reg >> 2) : len_reg;
   wire [5:0] addr_edges = dtr_reg ? (addr_sdr >> 1) + 6'd1 : addr_sdr;
   wire       addr_last  = (state_reg == ST_ADDR) && (cnt_reg == addr_edges - 6'd1);
   wire [35:0] rx_addr   = dtr_reg ? rx_dtr : rx_next;
   wire [31:0] raw_addr  = !dtr_reg ? rx_addr[31:0] : qpi_reg ? rx_addr[35:4] : rx_addr[32:1];
   wire [31:0] full_addr = (len_reg == ADDR4_BITS) ? raw_addr
                         : {ext_addr_reg, raw_addr[23:0]};
   wire [3:0] dummy_left = dtr_reg ? dummy_reg - 4'd1 : dummy_reg;

   // ==========================================================
   // next phase after the instruction byte
   link_state_t cmd_state;
   always_comb begin
      if (busy_s) begin
         cmd_state = ST_IGNORE;
      end else if (op_read) begin
         cmd_state = wip_s ? ST_IGNORE : ST_ADDR;
      end else if (op_param || op_ext) begin
         cmd_state = ST_BYTE;
      end else begin
         cmd_state = ST_IGNORE;
      end
   end

   // ==========================================================
   // persistent mode state, kept across frames
   always_ff @(posedge sclk_i or posedge reset_i) begin
      if (reset_i) begin
         four_byte_reg <= 1'b0;
         qpi_reg       <= 1'b0;
         armed_reg     <= 1'b0;
         rst_tog_reg   <= 1'b0;
         ext_addr_reg  <= EXT_ADDR_RESET;
         param_reg     <= READ_PARAM_RESET;
      end else if (busy_s) begin
         four_byte_reg <= 1'b0;
         qpi_reg       <= 1'b0;
         armed_reg     <= 1'b0;
         ext_addr_reg  <= EXT_ADDR_RESET;
         param_reg     <= READ_PARAM_RESET;
      end else if (cmd_done) begin
         armed_reg <= (opcode == OP_RESET_ENABLE);
         unique case (opcode)
            OP_ENTER_4B: four_byte_reg <= 1'b1;
            OP_EXIT_4B: four_byte_reg <= 1'b0;
            OP_ENTER_QUAD: begin
               if (qe_s) begin
                  qpi_reg <= 1'b1;
               end
            end
            OP_EXIT_QUAD: qpi_reg <= 1'b0;
            OP_RESET: begin
               if (armed_reg) begin
                  four_byte_reg <= 1'b0;
                  qpi_reg       <= 1'b0;
                  ext_addr_reg  <= EXT_ADDR_RESET;
                  param_reg     <= READ_PARAM_RESET;
                  rst_tog_reg   <= ~rst_tog_reg;
               end
            end
            default: ;
         endcase
      end else if (byte_done) begin
         if (ext_sel_reg) begin
            ext_addr_reg <= rx_next[7:0];
         end else begin
            param_reg <= rx_next[7:0];
         end
      end
   end

   // ==========================================================
   // input side of a frame, cleared while deselected
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         state_reg   <= ST_CMD;
         cnt_reg     <= 6'd0;
         rx_reg      <= 36'h0;
         len_reg     <= ADDR3_BITS;
         dummy_reg   <= 4'd0;
         dtr_reg     <= 1'b0;
         wrap_reg    <= 1'b0;
         ext_sel_reg <= 1'b0;
         addr_reg    <= 32'h0;
         rise_q_reg  <= 4'h0;
      end else begin
         cnt_reg <= cnt_reg + 6'd1;
         unique case (state_reg)
            ST_CMD: begin
               rx_reg <= rx_next;
               if (cmd_done) begin
                  cnt_reg     <= 6'd0;
                  state_reg   <= cmd_state;
                  len_reg     <= op_len;
                  dummy_reg   <= op_dummy;
                  dtr_reg     <= op_dtr;
                  wrap_reg    <= op_wrap;
                  ext_sel_reg <= (opcode == OP_WRITE_EXT);
               end
            end
            ST_ADDR: begin
               rx_reg <= rx_addr;
               if (addr_last) begin
                  addr_reg  <= full_addr;
                  cnt_reg   <= 6'd0;
                  state_reg <= (dummy_left == 4'd0) ? ST_DATA : ST_DUMMY;
                  dummy_reg <= dummy_left;
               end
            end
            ST_DUMMY: begin
               if (cnt_reg == {2'b00, dummy_reg} - 6'd1) begin
                  state_reg <= ST_DATA;
               end
            end
            ST_BYTE: begin
               rx_reg <= rx_next;
               if (byte_done) begin
                  state_reg <= ST_IGNORE;
               end
            end
            ST_DATA: rise_q_reg <= group_sel(tx_reg, pos_reg - 4'd1, qpi_reg);
            ST_IGNORE: cnt_reg <= cnt_reg;
         endcase
      end
   end

   // ==========================================================
   // output side: one group per falling edge, next byte fetched on wrap
   wire [3:0] groups = qpi_reg ? QUAD_GROUPS : SPI_GROUPS;
   wire [3:0] step   = dtr_reg ? 4'd2 : 4'd1;
   wire       fetch  = (pos_reg >= groups);

   always_ff @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         fall_in_reg <= 4'h0;
         fall_q_reg  <= 4'h0;
         tx_reg      <= 8'h00;
         pos_reg     <= SPI_GROUPS;
         loaded_reg  <= 1'b0;
         rd_addr_reg <= 32'h0;
      end else begin
         fall_in_reg <= io_i;
         if (state_reg == ST_DATA) begin
            if (fetch) begin
               tx_reg      <= mem_data_i;
               fall_q_reg  <= group_sel(mem_data_i, 4'd0, qpi_reg);
               pos_reg     <= step;
               loaded_reg  <= 1'b1;
               rd_addr_reg <= next_addr(mem_addr_o, wrap_reg, param_reg[1:0]);
            end else begin
               fall_q_reg <= group_sel(tx_reg, pos_reg, qpi_reg);
               pos_reg    <= pos_reg + step;
            end
         end
      end
   end

   // ==========================================================
   // pins and memory view; double rate selects by clock level
   assign io_o       = (dtr_reg && sclk_i) ? rise_q_reg : fall_q_reg;
   assign io_oe_o    = (state_reg != ST_DATA) ? 4'h0 : qpi_reg ? QUAD_OUT_OE : SPI_OUT_OE;
   assign mem_addr_o = loaded_reg ? rd_addr_reg : addr_reg;
   assign mem_rd_o   = (state_reg == ST_DATA);

endmodule

// ---- verif/flash_cmd_core_checker.sv ----
// assertion checker for the flash instruction interpreter
`timescale 1ns/1ps
module flash_cmd_core_checker
   import flash_cmd_pkg::*;
#(
   parameter int RECOVERY_CYCLES = 20
) (
   input wire logic       ref_clk_i,
   input wire logic       reset_i,
   input wire logic       cs_n_i,
   input wire logic [3:0] io_oe_o,
   input wire logic       quad_enable_bit_i,
   input wire logic       write_in_progress_flag_i,
   input wire logic       quad_command_mode_o,
   input wire logic       soft_reset_o,
   input wire logic       reset_busy_o,
   input wire logic       mem_rd_o
);
   logic [15:0] busy_run_reg;
   logic [7:0]  wip_run_reg;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // ==========================================
   // run lengths of recovery and of a steady write in progress
   always_ff @(posedge ref_clk_i) begin
      busy_run_reg <= (reset_busy_o && !reset_i) ? busy_run_reg + 16'h0001 : 16'h0000;
      wip_run_reg  <= !write_in_progress_flag_i ? 8'h00 : wip_run_reg + {7'h00, wip_run_reg != 8'hff};
   end
   // ==========================================
   // properties
   a_busy_at_release: assert property ($fell(reset_i) |-> reset_busy_o)
      else $error("recovery not running after reset release");
   a_busy_full_length: assert property ($fell(reset_busy_o) |-> busy_run_reg >= RECOVERY_CYCLES - 1)
      else $error("recovery ended early");
   a_pulse_single: assert property (soft_reset_o |=> !soft_reset_o)
      else $error("soft reset pulse longer than one cycle");
   a_pulse_starts_busy: assert property (soft_reset_o |-> ##[0:1] reset_busy_o)
      else $error("soft reset without recovery");
   a_oe_legal: assert property (io_oe_o == 4'h0 || io_oe_o == SPI_OUT_OE || io_oe_o == QUAD_OUT_OE)
      else $error("illegal output enable pattern");
   a_deselect_quiet: assert property (cs_n_i |-> io_oe_o == 4'h0 && !mem_rd_o)
      else $error("device active while deselected");
   a_read_drives: assert property (mem_rd_o |-> io_oe_o != 4'h0)
      else $error("data phase without driven lines");
   a_wip_blocks_read: assert property (wip_run_reg == 8'hff |-> !mem_rd_o)
      else $error("read served during write in progress");
   a_quad_needs_qe: assert property ($rose(quad_command_mode_o) |-> quad_enable_bit_i)
      else $error("quad mode entered with quad enable clear");
endmodule
bind flash_cmd_core flash_cmd_core_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_flash_cmd_core_checker (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o),
   .quad_enable_bit_i(quad_enable_bit_i), .write_in_progress_flag_i(write_in_progress_flag_i),
   .quad_command_mode_o(quad_command_mode_o), .soft_reset_o(soft_reset_o),
   .reset_busy_o(reset_busy_o), .mem_rd_o(mem_rd_o));

// ---- verif/flash_host_model.sv ----
// behavioural spi and quad host driving the flash link
`timescale 1ns/1ps
module flash_host_model (
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic      [3:0] line_o,
   input  wire logic [3:0] dev_io_i,
   input  wire logic [3:0] dev_oe_i
);
   localparam realtime HALF = 62.5;
   logic       host_oe = 1'b0;
   logic [3:0] drv     = 4'h0;
   logic [3:0] idle    = 4'h5;
   initial sclk_o = 1'b0;
   initial cs_n_o = 1'b1;
   // wire level: host, else device, else the inverse of the last level
   assign line_o = host_oe ? drv : ((dev_oe_i & dev_io_i) | (~dev_oe_i & idle));
   // select, off the reference clock phase
   task automatic open_frame();
      #1.3;
      cs_n_o = 1'b0;
   endtask
   // n clocks of v, msb first, a bit or a nibble per clock, changed after falling edges
   task automatic shift(input logic [31:0] v, input int n, input bit quad);
      for (int k = n - 1; k >= 0; k--) begin
         host_oe = 1'b1;
         drv = quad ? v[4*k +: 4] : {3'b000, v[k]};
         #HALF;
         sclk_o = 1'b1;
         #HALF;
         sclk_o = 1'b0;
      end
   endtask
   // n groups from the device, sampled just before each rising edge
   task automatic fetch(output logic [31:0] v, input int n, input bit quad);
      v = 32'h0;
      idle = ~line_o;
      host_oe = 1'b0;
      for (int k = 0; k < n; k++) begin
         #HALF;
         v = quad ? {v[27:0], line_o} : {v[30:0], line_o[1]};
         sclk_o = 1'b1;
         #HALF;
         sclk_o = 1'b0;
      end
   endtask
   // deselect; clock stands low until the next frame
   task automatic close_frame();
      #HALF;
      idle = ~line_o;
      host_oe = 1'b0;
      cs_n_o = 1'b1;
      #(4*HALF);
   endtask
endmodule

// ---- verif/flash_cmd_core_bench.sv ----
// self-checking bench for the flash instruction interpreter
`timescale 1ns/1ps
module flash_cmd_core_bench;
   import flash_cmd_pkg::*;
   logic        ref_clk, reset, qe, write_in_progress_flag, sclk, cs_n, addr_size, quad, soft_rst, busy, mem_rd;
   logic [3:0]  line, io_o, io_oe;
   logic [31:0] mem_addr;
   logic [7:0]  mem_data;
   int          n_fail = 0;
   int          check_count = 0;
   int          pulses = 0;
   int          cycles = 0;
   // memory contents are a pattern of the address
   function automatic logic [7:0] pat(input logic [31:0] a);
      return a[7:0] ^ a[31:24] ^ 8'h5a;
   endfunction
   assign mem_data = pat(mem_addr);
   flash_cmd_core #(.RECOVERY_CYCLES(600)) u_flash_cmd_core (.ref_clk_i(ref_clk), .reset_i(reset), .sclk_i(sclk),
      .cs_n_i(cs_n), .io_i(line), .io_o(io_o), .io_oe_o(io_oe), .quad_enable_bit_i(qe),
      .write_in_progress_flag_i(write_in_progress_flag), .write_enable_latch_i(1'b0), .address_size_bit_o(addr_size),
      .quad_command_mode_o(quad), .soft_reset_o(soft_rst), .reset_busy_o(busy), .mem_addr_o(mem_addr),
      .mem_rd_o(mem_rd), .mem_data_i(mem_data));
   flash_host_model u_flash_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .line_o(line), .dev_io_i(io_o),
      .dev_oe_i(io_oe));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // pulse count and hang limit
   always @(negedge ref_clk) begin
      cycles++;
      if (soft_rst === 1'b1) pulses++;
      if (cycles == 60000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input bit q);
      u_flash_host_model.open_frame();
      u_flash_host_model.shift({24'h0, op}, q ? 2 : 8, q);
      u_flash_host_model.close_frame();
   endtask
   // read three bytes; a refused read must leave the lines released
   task automatic rd(input logic [7:0] op, input logic [31:0] a, input int ab, input int dum, input bit q, input bit ok);
      logic [31:0] v;
      int w;
      w = q ? 4 : 1;
      u_flash_host_model.open_frame();
      u_flash_host_model.shift({24'h0, op}, 8 / w, q);
      u_flash_host_model.shift(a, ab / w, q);
      if (dum > 0) u_flash_host_model.shift(32'h0, dum, q);
      for (int i = 0; i < 3; i++) begin
         u_flash_host_model.fetch(v, 8 / w, q);
         if (ok) chk("read byte", {24'h0, pat(a + 32'(i))}, v);
         else chk("refused read", 32'h0, 32'({io_oe, mem_rd}));
      end
      u_flash_host_model.close_frame();
   endtask
   task automatic wait_ready();
      for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge ref_clk);
      chk("busy", 32'h0, 32'(busy));
      cmd(8'h00, 1'b0);
   endtask
   task automatic t_power();
      chk("busy", 32'h1, 32'(busy));
      @(negedge ref_clk) reset = 1'b0;
      wait_ready();
      chk("quad mode", 32'h0, 32'(quad));
      chk("addr size", 32'h0, 32'(addr_size));
      rd(OP_READ, 32'h001234fe, 24, 0, 1'b0, 1'b1);
      $display("test power done");
   endtask
   task automatic t_addr();
      cmd(OP_ENTER_4B, 1'b0);
      chk("addr size", 32'h1, 32'(addr_size));
      rd(OP_READ, 32'hab0000ff, 32, 0, 1'b0, 1'b1);
      cmd(OP_EXIT_4B, 1'b0);
      chk("addr size", 32'h0, 32'(addr_size));
      rd(OP_READ_4B, 32'hc1000010, 32, 0, 1'b0, 1'b1);
      rd(OP_FAST_READ, 32'h00000777, 24, int'(SPI_FAST_DUMMY), 1'b0, 1'b1);
      rd(OP_FAST_READ_4B, 32'h7f00aa00, 32, int'(SPI_FAST_DUMMY), 1'b0, 1'b1);
      $display("test address modes done");
   endtask
   task automatic t_wip();
      @(negedge ref_clk) write_in_progress_flag = 1'b1;
      rd(OP_READ, 32'h00000040, 24, 0, 1'b0, 1'b0);
      rd(OP_READ_4B, 32'h00000040, 32, 0, 1'b0, 1'b0);
      @(negedge ref_clk) write_in_progress_flag = 1'b0;
      $display("test write in progress done");
   endtask
   task automatic t_quad();
      cmd(OP_ENTER_QUAD, 1'b0);
      chk("quad mode", 32'h0, 32'(quad));
      @(negedge ref_clk) qe = 1'b1;
      cmd(OP_ENTER_QUAD, 1'b0);
      chk("quad mode", 32'h1, 32'(quad));
      rd(OP_FAST_READ, 32'h00000123, 24, 4, 1'b1, 1'b1);
      u_flash_host_model.open_frame();
      u_flash_host_model.shift({16'h0, OP_SET_PARAM, 8'h20}, 4, 1'b1);
      u_flash_host_model.close_frame();
      rd(OP_FAST_READ, 32'h00000456, 24, 6, 1'b1, 1'b1);
      rd(OP_READ_4B, 32'h00000123, 32, 0, 1'b1, 1'b0);
      cmd(OP_EXIT_QUAD, 1'b1);
      chk("quad mode", 32'h0, 32'(quad));
      $display("test quad mode done");
   endtask
   task automatic t_soft();
      int p;
      p = pulses;
      chk("busy before reset", 32'h0, 32'(busy));
      chk("write in progress", 32'h0, 32'(write_in_progress_flag));
      cmd(OP_RESET_ENABLE, 1'b0);
      cmd(OP_EXIT_4B, 1'b0);
      cmd(OP_RESET, 1'b0);
      chk("reset pulses", 32'(p), 32'(pulses));
      cmd(OP_ENTER_4B, 1'b0);
      cmd(OP_RESET_ENABLE, 1'b0);
      cmd(OP_RESET, 1'b0);
      chk("reset pulses", 32'(p + 1), 32'(pulses));
      cmd(OP_ENTER_QUAD, 1'b0);
      chk("quad mode", 32'h0, 32'(quad));
      wait_ready();
      chk("addr size", 32'h0, 32'(addr_size));
      $display("test soft reset done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      qe = 1'b0;
      write_in_progress_flag = 1'b0;
      repeat (8) @(negedge ref_clk);
      t_power();
      t_addr();
      t_wip();
      t_quad();
      t_soft();
      give_verdict();
   end
endmodule
